//--- dv/mps_plant_model.sv
`timescale 1ns/1ps
// motor and host side of the drive
module mps_plant_model
    import mps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire mps_drive_type drive,
    output logic below_stop_speed
);
    logic [7:0] speed_reg;
    logic [15:0] coord_reg;
    logic servo_reg;

    // motor slows one unit a cycle once the sequence holds it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            speed_reg <= 8'h28;
        end else if (drive.force_position && speed_reg != 8'h00) begin
            speed_reg <= speed_reg - 8'h01;
        end
    end
    assign below_stop_speed = speed_reg < 8'h1E; // threshold speed

    // host re-zeroes its coordinate on each servo restart, else it would jump
    always_ff @(posedge clk_sys) begin
        servo_reg <= drive.servo_enable;
        if (rst || (drive.servo_enable && !servo_reg)) begin
            coord_reg <= 16'h0000;
        end else if (drive.servo_enable) begin
            coord_reg <= coord_reg + 16'h0001;
        end
    end
endmodule

//--- dv/mps_sequencer_assertions.sv
`timescale 1ns/1ps
// watches the sequencer ports for stop-sequence consistency
module mps_sequencer_checker
    import mps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic main_power_ok,
    input wire logic pole_or_setup_active,
    input wire mps_drive_type drive,
    input wire logic low_voltage_trip
);
    logic [21:0] absent_cnt;

    // length of the current power gap, saturating past the shortest setting
    always_ff @(posedge clk_sys) begin
        if (rst || main_power_ok) begin
            absent_cnt <= 22'h0;
        end else if (absent_cnt != 22'h3FFFFF) begin
            absent_cnt <= absent_cnt + 22'h1;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_RDATA_IDLE:
        assert property (!$past(reg_read) |-> reg_rdata == 32'h0) else $error("read data outside answer cycle");
    AST_ESTOP_SERVO:
        assert property (drive.estop_active |-> drive.servo_enable) else $error("estop without servo");
    AST_BRAKE_EXCL:
        assert property (drive.dynamic_brake |-> !drive.estop_active) else $error("brake and estop together");
    AST_FORCE:
        assert property (drive.dynamic_brake || drive.estop_active |-> drive.force_position && drive.hold_command)
        else $error("stop without forced position");
    AST_TRACK:
        assert property (drive.force_position |-> drive.track_feedback) else $error("deviation not cleared");
    AST_LIMIT:
        assert property (drive.estop_active |-> drive.thrust_limit <= 9'h1F4
            && drive.use_normal_limit == (drive.thrust_limit == 9'h000)) else $error("estop thrust limit wrong");
    AST_POLE:
        assert property ($rose(drive.estop_active) |-> !$past(pole_or_setup_active)) else $error("estop in setup");
    AST_LV_HOLD:
        assert property ($past(low_voltage_trip) |-> low_voltage_trip) else $error("trip flag dropped");
    AST_LV_TIME:
        assert property ($rose(low_voltage_trip) |-> absent_cnt >= 22'h2AB980 || main_power_ok)
        else $error("trip before minimum detect time");

    // main scenarios reached
    cover property (drive.estop_active);
    cover property ($rose(drive.dynamic_brake));
    cover property ($past(reg_read) && reg_rdata != 32'h0);
endmodule

//--- dv/tb_mps_sequencer.sv
`timescale 1ns/1ps
module tb_mps_sequencer
    import mps_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic main_power_ok = 1'b1;
    logic servo_on_cmd = 1'b1;
    logic below_stop_speed;
    logic alarm_event = 1'b0;
    logic alarm_needs_estop = 1'b0;
    logic pole_or_setup_active = 1'b0;
    mps_drive_type drive;
    logic low_voltage_trip;
    logic irq;
    int failures = 0;
    int checked = 0;
    int mdl [8];
    int k;
    logic es;
    logic [8:0] tl;
    logic [31:0] seed = 32'h257FD055;
    logic [7:0] wa [10] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h08, 8'h08, 8'h10, 8'h10, 8'h04, 8'h0C};
    logic [31:0] wd [10] = '{32'h9, 32'hA, 32'h45, 32'h7D0, 32'h7D1, 32'h63, 32'h1F4, 32'h1F5, 32'h3, 32'h7};
    logic [7:0] ra [3] = '{OFS_POWER_OFF_SEL, OFS_DETECT_TIME, OFS_THRUST_LIM};
    logic [31:0] rm [3] = '{32'hF, 32'h7FF, 32'h1FF};

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    mps_sequencer i_mps_sequencer (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .main_power_ok(main_power_ok),
        .servo_on_cmd(servo_on_cmd), .below_stop_speed(below_stop_speed), .alarm_event(alarm_event),
        .alarm_needs_estop(alarm_needs_estop), .pole_or_setup_active(pole_or_setup_active), .drive(drive),
        .low_voltage_trip(low_voltage_trip), .irq(irq));

    mps_plant_model i_mps_plant_model (.clk_sys(clk_sys), .rst(rst), .drive(drive),
        .below_stop_speed(below_stop_speed));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // register model: refused values leave the old setting
    function automatic void mdl_write(input logic [7:0] a, input logic [31:0] d);
        case (a)
            OFS_POWER_OFF_SEL: if (d <= 32'h9) mdl[0] = int'(d);
            OFS_TRIP_SEL: mdl[1] = int'(d[1:0]);
            OFS_DETECT_TIME: if (d >= 32'h46 && d <= 32'h7D0) mdl[2] = int'(d);
            OFS_ALARM_SEL: mdl[3] = int'(d[2:0]);
            OFS_THRUST_LIM: if (d <= 32'h1F4) mdl[4] = int'(d);
            OFS_IRQ_MASK: mdl[7] = int'(d[3:0]);
            OFS_IRQ_STAT: mdl[6] = mdl[6] & ~int'(d[3:0]);
            default: ;
        endcase
    endfunction

    function automatic logic [31:0] exp_rd(input logic [7:0] a, input logic [31:0] st);
        if (a == OFS_STATUS) exp_rd = st;
        else if (a > OFS_IRQ_MASK) exp_rd = 32'h0;
        else exp_rd = mdl[a >> 2];
    endfunction

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        mdl_write(a, d);
    endtask

    // read data are valid only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] st);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata, exp_rd(a, st));
    endtask

    task automatic do_reset(input int n);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (n) @(posedge clk_sys);
        rst <= 1'b0;
        mdl = '{0, 0, 70, 0, 0, 0, 0, 0};
    endtask

    task automatic chk_drive(input logic db, input logic e);
        check({drive.force_position, drive.hold_command, drive.track_feedback, drive.servo_enable,
            drive.dynamic_brake, drive.estop_active}, {3'b111, e, db, e});
    endtask

    task automatic stop_test;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // a hang costs several times the whole run
    initial begin
        #500000;
        failures++;
        stop_test;
    end

    initial begin
        do_reset(8);
        for (int i = 0; i < 9; i++) rd_chk(8'(i * 4), 32'h10);
        // boundary settings, refused ones included
        foreach (wa[i]) begin
            wr(wa[i], wd[i]);
            rd_chk(wa[i], 32'h10);
        end
        repeat (8) begin
            seed = lfsr(seed);
            k = int'(seed[1:0]) % 3;
            wr(ra[k], seed[31:8] & rm[k]);
            rd_chk(ra[k], 32'h10);
        end
        wr(OFS_IRQ_MASK, 32'hF);
        wr(OFS_IRQ_STAT, 32'hF);
        rd_chk(OFS_IRQ_MASK, 32'h10);
        check({31'h0, irq}, 32'h0);
        // short power gap far below the minimum detect time
        @(posedge clk_sys);
        main_power_ok <= 1'b0;
        repeat (2000) @(posedge clk_sys);
        main_power_ok <= 1'b1;
        rd_chk(OFS_STATUS, 32'h10);
        check({31'h0, low_voltage_trip}, 32'h0);
        // every alarm selector, with and without an estop alarm
        for (int a = 0; a < 16; a++) begin
            do_reset(2);
            seed = lfsr(seed);
            tl = 9'(seed[15:0] % 501);
            wr(OFS_ALARM_SEL, 32'(a >> 1));
            wr(OFS_THRUST_LIM, {23'h0, tl});
            @(posedge clk_sys);
            pole_or_setup_active <= seed[20];
            alarm_needs_estop <= a[0];
            alarm_event <= 1'b1;
            @(posedge clk_sys);
            alarm_event <= 1'b0;
            // first decel cycle already shows the final action
            #1;
            es = (a >= 8) && a[0] && !seed[20];
            chk_drive(!es && !a[1], es);
            if (es) check({drive.use_normal_limit, drive.thrust_limit}, {tl == 9'h000, tl});
            for (int n = 0; n < 50 && !below_stop_speed; n++) @(posedge clk_sys);
            repeat (4) @(posedge clk_sys);
            #1;
            chk_drive(!a[2], 1'b0);
            rd_chk(OFS_STATUS, 32'h54);
            // stop entry is sticky, unmasked it raises irq, a one clears it
            mdl[6] = 1 << IRQ_STOPPED;
            rd_chk(OFS_IRQ_STAT, 32'h0);
            wr(OFS_IRQ_MASK, 32'h4);
            #1;
            check({31'h0, irq}, 32'h1);
            wr(OFS_IRQ_STAT, 32'h4);
            #1;
            check({31'h0, irq}, 32'h0);
        end
        stop_test;
    end
endmodule

bind mps_sequencer mps_sequencer_checker i_mps_sequencer_checker (.clk_sys(clk_sys), .rst(rst),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .main_power_ok(main_power_ok),
    .pole_or_setup_active(pole_or_setup_active), .drive(drive), .low_voltage_trip(low_voltage_trip));

//--- rtl/mps_loss_timer.sv
`timescale 1ns/1ps
// counts 2 ms steps of continuous power absence
module mps_loss_timer
    import mps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic absent,
    input wire logic arm,
    input wire logic [10:0] detect_time,
    output logic expired
);
    logic [21:0] tick_reg;
    logic [21:0] tick_next;
    logic [10:0] steps_reg;
    logic [10:0] steps_next;
    logic expired_reg;
    logic expired_next;
    logic step_done;
    logic [10:0] step_goal;
    logic disabled;

    // odd settings round up to the next step
    assign step_goal = (detect_time < DETECT_TIME_MIN) ? (DETECT_TIME_MIN >> 1) :
                       11'((detect_time + 11'h001) >> 1);
    assign disabled = (detect_time >= DETECT_TIME_OFF);
    assign step_done = (tick_reg == 22'(STEP_CYCLES - 1));
    assign tick_next = (!absent || !arm || step_done) ? 22'h000000 : 22'(tick_reg + 22'h000001);
    assign steps_next = (!absent || !arm) ? 11'h000 :
                        (step_done && steps_reg != step_goal) ? 11'(steps_reg + 11'h001) : steps_reg;
    // a power blip resets the count, detection needs continuous absence
    assign expired_next = absent && arm && !disabled && (steps_reg == step_goal);
    assign expired = expired_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_reg <= 22'h000000;
            steps_reg <= 11'h000;
            expired_reg <= 1'b0;
        end else begin
            tick_reg <= tick_next;
            steps_reg <= steps_next;
            expired_reg <= expired_next;
        end
    end
endmodule

//--- rtl/mps_pkg.sv
package mps_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_POWER_OFF_SEL = 8'h00;
    localparam logic [7:0] OFS_TRIP_SEL = 8'h04;
    localparam logic [7:0] OFS_DETECT_TIME = 8'h08;
    localparam logic [7:0] OFS_ALARM_SEL = 8'h0C;
    localparam logic [7:0] OFS_THRUST_LIM = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
    // reset values
    localparam logic [3:0] RST_POWER_OFF_SEL = 4'h0;
    localparam logic [1:0] RST_TRIP_SEL = 2'h0;
    localparam logic [10:0] RST_DETECT_TIME = 11'h046;
    localparam logic [2:0] RST_ALARM_SEL = 3'h0;
    localparam logic [8:0] RST_THRUST_LIM = 9'h000;
    // setting limits
    localparam logic [3:0] POWER_OFF_SEL_MAX = 4'h9;
    localparam logic [10:0] DETECT_TIME_MIN = 11'h046;
    localparam logic [10:0] DETECT_TIME_OFF = 11'h7D0;
    localparam logic [8:0] THRUST_LIM_MAX = 9'h1F4;
    // trip select fields
    localparam int TRIP_BIT_LV = 0;
    localparam int TRIP_BIT_ALWAYS = 1;
    // detection step timing
    localparam int CLK_HZ = 40000000;
    localparam int STEP_MS = 2;
    localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
    // interrupt bits
    localparam int IRQ_LOSS = 0;
    localparam int IRQ_LV = 1;
    localparam int IRQ_STOPPED = 2;
    localparam int IRQ_RESTORE = 3;
    localparam int IRQ_W = 4;

    typedef enum logic [2:0] {
        MPS_RUN = 3'b000,
        MPS_DECEL = 3'b001,
        MPS_STOP = 3'b010,
        MPS_ALARM_DECEL = 3'b011,
        MPS_ALARM_STOP = 3'b100
    } mps_state_type;

    // action applied to the power stage
    typedef enum logic [1:0] {
        MPS_ACT_NONE = 2'b00,
        MPS_ACT_BRAKE = 2'b01,
        MPS_ACT_FREE = 2'b10,
        MPS_ACT_ESTOP = 2'b11
    } mps_act_type;

    typedef struct packed {
        logic force_position;
        logic hold_command;
        logic track_feedback;
        logic servo_enable;
        logic dynamic_brake;
        logic estop_active;
        logic use_normal_limit;
        logic [8:0] thrust_limit;
    } mps_drive_type;

    // decel action, after-stop action of a selector value
    function automatic mps_act_type mps_decel_act(input logic [3:0] sel, input logic emerg_ok);
        if (sel >= 4'h8) begin
            mps_decel_act = emerg_ok ? MPS_ACT_ESTOP : MPS_ACT_BRAKE;
        end else begin
            mps_decel_act = sel[0] ? MPS_ACT_FREE : MPS_ACT_BRAKE;
        end
    endfunction

    function automatic mps_act_type mps_stop_act(input logic [3:0] sel);
        if (sel >= 4'h8) begin
            mps_stop_act = sel[0] ? MPS_ACT_FREE : MPS_ACT_BRAKE;
        end else begin
            mps_stop_act = sel[1] ? MPS_ACT_FREE : MPS_ACT_BRAKE;
        end
    endfunction
endpackage

//--- rtl/mps_sequencer.sv
`timescale 1ns/1ps
// Function
// - selector 0-7 picks brake or free phases
// - selector 8,9 emergency stop then brake/free
// - force position control, hold command generation
// - command follows feedback in both phases
// - below 30 mm/s counts as stopped
// - trip bit0 servo-off with restart or trip
// - trip bit1 detect always or servo-on only
// - detect time 70-2000 ms, 2000 disables
// - detect time handled in 2 ms steps
// - thrust limit 0-500, zero means normal
// - any error uses alarm stop sequence
// - servo-on loss with trip raises undervoltage
// - pole estimation or setup: brake, no estop; alarm 5,7 run free
// - alarm selector 0-7 defines alarm stop
// - alarm 4-7: estop alarms use emergency stop
module mps_sequencer
    import mps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic main_power_ok,
    input wire logic servo_on_cmd,
    input wire logic below_stop_speed,
    input wire logic alarm_event,
    input wire logic alarm_needs_estop,
    input wire logic pole_or_setup_active,
    output mps_drive_type drive,
    output logic low_voltage_trip,
    output logic irq
);
    // parameter registers
    logic [3:0] power_off_stop_select_reg;
    logic [1:0] power_loss_trip_select_reg;
    logic [10:0] power_loss_detect_time_reg;
    logic [2:0] alarm_stop_select_reg;
    logic [8:0] emergency_thrust_limit_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_stat_next;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    // sequencer state
    mps_state_type state_reg;
    mps_state_type state_next;
    logic alarm_reg;
    logic alarm_next;
    logic alarm_estop_reg;
    logic alarm_estop_next;
    logic lv_reg;
    logic lv_next;
    logic prev_power_reg;
    mps_drive_type drive_reg;
    mps_drive_type drive_next;

    logic wr_power_off_sel;
    logic wr_trip_sel;
    logic wr_detect_time;
    logic wr_alarm_sel;
    logic wr_thrust_lim;
    logic wr_irq_stat;
    logic wr_irq_mask;
    logic loss_arm;
    logic loss_detected;
    logic loss_start;
    logic lv_trip_now;
    logic power_back;
    logic entering_stop;
    logic in_sequence;
    logic in_alarm;
    logic stopped;
    logic estop_allowed;
    logic [3:0] alarm_sel_ext;
    mps_act_type power_decel;
    mps_act_type power_after;
    mps_act_type alarm_decel;
    mps_act_type alarm_after;
    mps_act_type act_now;
    logic [IRQ_W-1:0] irq_events;

    // write decode
    assign wr_power_off_sel = reg_write && (reg_addr == OFS_POWER_OFF_SEL);
    assign wr_trip_sel = reg_write && (reg_addr == OFS_TRIP_SEL);
    assign wr_detect_time = reg_write && (reg_addr == OFS_DETECT_TIME);
    assign wr_alarm_sel = reg_write && (reg_addr == OFS_ALARM_SEL);
    assign wr_thrust_lim = reg_write && (reg_addr == OFS_THRUST_LIM);
    assign wr_irq_stat = reg_write && (reg_addr == OFS_IRQ_STAT);
    assign wr_irq_mask = reg_write && (reg_addr == OFS_IRQ_MASK);

    // parameter writes; out-of-range values are ignored so the setting stays legal
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            power_off_stop_select_reg <= RST_POWER_OFF_SEL;
            power_loss_trip_select_reg <= RST_TRIP_SEL;
            power_loss_detect_time_reg <= RST_DETECT_TIME;
            alarm_stop_select_reg <= RST_ALARM_SEL;
            emergency_thrust_limit_reg <= RST_THRUST_LIM;
            irq_mask_reg <= '0;
        end else begin
            if (wr_power_off_sel && reg_wdata[31:4] == 28'h0 && reg_wdata[3:0] <= POWER_OFF_SEL_MAX) begin
                power_off_stop_select_reg <= reg_wdata[3:0];
            end
            if (wr_trip_sel) begin
                power_loss_trip_select_reg <= reg_wdata[1:0];
            end
            if (wr_detect_time && reg_wdata[31:11] == 21'h0 && reg_wdata[10:0] >= DETECT_TIME_MIN &&
                reg_wdata[10:0] <= DETECT_TIME_OFF) begin
                power_loss_detect_time_reg <= reg_wdata[10:0];
            end
            if (wr_alarm_sel) begin
                alarm_stop_select_reg <= reg_wdata[2:0];
            end
            if (wr_thrust_lim && reg_wdata[31:9] == 23'h0 && reg_wdata[8:0] <= THRUST_LIM_MAX) begin
                emergency_thrust_limit_reg <= reg_wdata[8:0];
            end
            if (wr_irq_mask) begin
                irq_mask_reg <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    // loss detection gate: servo-on only, or always
    assign loss_arm = power_loss_trip_select_reg[TRIP_BIT_ALWAYS] || servo_on_cmd || in_sequence;

    mps_loss_timer u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .absent(!main_power_ok),
        .arm(loss_arm),
        .detect_time(power_loss_detect_time_reg),
        .expired(loss_detected)
    );

    assign in_sequence = (state_reg != MPS_RUN);
    assign in_alarm = (state_reg == MPS_ALARM_DECEL) || (state_reg == MPS_ALARM_STOP);
    assign loss_start = loss_detected && !in_sequence;
    // trip instead of servo-off when bit0 is set and servo was on
    assign lv_trip_now = loss_start && power_loss_trip_select_reg[TRIP_BIT_LV] && servo_on_cmd;
    assign power_back = main_power_ok && !prev_power_reg;
    assign estop_allowed = !pole_or_setup_active;
    assign alarm_sel_ext = {1'b0, alarm_stop_select_reg};

    // action tables for both selectors
    assign power_decel = mps_decel_act(power_off_stop_select_reg, estop_allowed);
    assign power_after = mps_stop_act(power_off_stop_select_reg);
    // alarm values 4-7 use estop only for alarms that ask for it;
    // qualifier taken from this cycle so no brake pulse precedes the estop
    assign alarm_decel = (alarm_stop_select_reg[2] && alarm_estop_next && estop_allowed) ? MPS_ACT_ESTOP :
                         (alarm_sel_ext[0] ? MPS_ACT_FREE : MPS_ACT_BRAKE);
    assign alarm_after = alarm_sel_ext[1] ? MPS_ACT_FREE : MPS_ACT_BRAKE;

    // state transitions; alarms take over any power-off sequence
    always_comb begin
        state_next = state_reg;
        alarm_next = alarm_reg;
        alarm_estop_next = alarm_estop_reg;
        lv_next = lv_reg;
        if (alarm_event || lv_trip_now) begin
            alarm_next = 1'b1;
            alarm_estop_next = alarm_event ? alarm_needs_estop : 1'b0;
            lv_next = lv_reg || lv_trip_now;
            if (!in_alarm) begin
                state_next = MPS_ALARM_DECEL;
            end
        end else begin
            case (state_reg)
                MPS_RUN: begin
                    if (loss_start) begin
                        state_next = MPS_DECEL;
                    end
                end
                MPS_DECEL: begin
                    if (below_stop_speed) begin
                        state_next = MPS_STOP;
                    end
                end
                MPS_STOP: begin
                    // stays stopped whatever the later speed; restart on power return
                    if (main_power_ok && power_back) begin
                        state_next = MPS_RUN;
                    end
                end
                MPS_ALARM_DECEL: begin
                    if (below_stop_speed) begin
                        state_next = MPS_ALARM_STOP;
                    end
                end
                MPS_ALARM_STOP: begin
                    // alarm is left only by reset; clearing lies outside this block
                    state_next = MPS_ALARM_STOP;
                end
                default: begin
                    state_next = MPS_RUN;
                end
            endcase
        end
    end

    assign entering_stop = ((state_next == MPS_STOP) || (state_next == MPS_ALARM_STOP)) &&
                           ((state_reg == MPS_DECEL) || (state_reg == MPS_ALARM_DECEL));
    assign stopped = (state_next == MPS_STOP) || (state_next == MPS_ALARM_STOP);

    // select the action for the coming state
    always_comb begin
        case (state_next)
            MPS_DECEL: act_now = power_decel;
            MPS_STOP: act_now = power_after;
            MPS_ALARM_DECEL: act_now = alarm_decel;
            MPS_ALARM_STOP: act_now = alarm_after;
            default: act_now = MPS_ACT_NONE;
        endcase
    end

    // drive outputs
    always_comb begin
        drive_next = '0;
        drive_next.servo_enable = (act_now == MPS_ACT_NONE) || (act_now == MPS_ACT_ESTOP);
        drive_next.force_position = (state_next != MPS_RUN);
        drive_next.hold_command = (state_next != MPS_RUN);
        // deviation cleared by tracking feedback, in every selector setting
        drive_next.track_feedback = (state_next != MPS_RUN);
        drive_next.dynamic_brake = (act_now == MPS_ACT_BRAKE);
        drive_next.estop_active = (act_now == MPS_ACT_ESTOP);
        drive_next.use_normal_limit = (emergency_thrust_limit_reg == 9'h000);
        drive_next.thrust_limit = emergency_thrust_limit_reg;
    end

    // sticky events; set wins over a clearing write
    assign irq_events[IRQ_LOSS] = loss_start;
    assign irq_events[IRQ_LV] = lv_trip_now;
    assign irq_events[IRQ_STOPPED] = entering_stop && stopped;
    assign irq_events[IRQ_RESTORE] = (state_reg == MPS_STOP) && (state_next == MPS_RUN);
    assign irq_stat_next = (irq_stat_reg & ~(wr_irq_stat ? reg_wdata[IRQ_W-1:0] : '0)) | irq_events;

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_next = 32'h00000000;
        if (reg_read) begin
            case (reg_addr)
                OFS_POWER_OFF_SEL: rdata_next = {28'h0, power_off_stop_select_reg};
                OFS_TRIP_SEL: rdata_next = {30'h0, power_loss_trip_select_reg};
                OFS_DETECT_TIME: rdata_next = {21'h0, power_loss_detect_time_reg};
                OFS_ALARM_SEL: rdata_next = {29'h0, alarm_stop_select_reg};
                OFS_THRUST_LIM: rdata_next = {23'h0, emergency_thrust_limit_reg};
                OFS_STATUS: rdata_next = {24'h0, lv_reg, alarm_reg, loss_detected, main_power_ok,
                                          1'b0, state_reg};
                OFS_IRQ_STAT: rdata_next = {28'h0, irq_stat_reg};
                OFS_IRQ_MASK: rdata_next = {28'h0, irq_mask_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    // state and output flops
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= MPS_RUN;
            alarm_reg <= 1'b0;
            alarm_estop_reg <= 1'b0;
            lv_reg <= 1'b0;
            prev_power_reg <= 1'b0;
            drive_reg <= '0;
            irq_stat_reg <= '0;
            rdata_reg <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            alarm_reg <= alarm_next;
            alarm_estop_reg <= alarm_estop_next;
            lv_reg <= lv_next;
            prev_power_reg <= main_power_ok;
            drive_reg <= drive_next;
            irq_stat_reg <= irq_stat_next;
            rdata_reg <= rdata_next;
        end
    end

    assign drive = drive_reg;
    assign low_voltage_trip = lv_reg;
    assign reg_rdata = rdata_reg;
    // level interrupt while any unmasked sticky bit is set
    assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule
